/* ema_accumulator.sv */
`timescale 1ns/10ps
// Function
// - interval off/5/10/15/30/60 minutes, thirty after reset
// - source is internal measurement or meter impulses, measurement by default
// - cumulation mode false or true, false by default
// - reference direction demand or supply decides power sign, demand by default
// - active and reactive pulse weights 1..10000, default 100
// - four totals kept: active and reactive, demand and supply, kilo or mega
// - clear input acts only while cumulation mode is true
// - four pulse inputs, used only in impulse mode
// - each interval end reports four totals to event list and supervisor
// - interval ends align to real-time clock minutes
// - any setting change zeroes all four totals at once
// - after a change, accumulation restarts at next boundary (at once with interval off), report one interval later
// - non-cumulative totals zero after report, cumulative ones keep adding
// - measurement adds positive power to demand, negative to supply
// - cumulated totals zero on clear input or device restart
module ema_accumulator (
  // clock and reset
  input  logic                         clk,
  input  logic                         sys_rst,
  input  logic                         clkEn,
  // register port
  input  logic [ema_pkg::ADDR_W-1:0]   regAddr,
  input  logic [ema_pkg::DATA_W-1:0]   regWrData,
  input  logic                         regWr,
  input  logic                         regRd,
  output logic [ema_pkg::DATA_W-1:0]   regRdData,
  // line measurement, same clock
  input  logic                         powerValid,
  input  logic signed [ema_pkg::POWER_W-1:0] activePower,
  input  logic signed [ema_pkg::POWER_W-1:0] reactivePower,
  // real-time clock, same clock
  input  logic                         rtcMinuteTick,
  input  logic [5:0]                   rtcMinute,
  // meter and clear pins
  input  logic                         totalClearIn,
  input  logic                         activeDemandPulseIn,
  input  logic                         activeSupplyPulseIn,
  input  logic                         reactiveDemandPulseIn,
  input  logic                         reactiveSupplyPulseIn,
  // totals and reports
  output ema_pkg::ema_totals_type      totals,
  output ema_pkg::ema_totals_type      reportTotals,
  output logic                         eventListStrobe,
  output logic                         supervisoryStrobe,
  output logic                         unitIsMega
);
  import ema_pkg::*;
  ema_cfg_type         cfg;
  logic [SCALE_W-1:0]  actScale;
  logic [SCALE_W-1:0]  reaScale;
  logic                waiting;
  ema_cfg_type         next_cfg;
  logic [SCALE_W-1:0]  next_actScale;
  logic [SCALE_W-1:0]  next_reaScale;
  logic                next_waiting;
  ema_totals_type      next_totals;
  ema_totals_type      next_reportTotals;
  logic                next_report;
  logic [DATA_W-1:0]   next_regRdData;
  logic [PIN_N-1:0]    pinVec;
  logic [PIN_N-1:0]    pinRise;
  logic                settingChange;
  logic                clearHit;
  logic                boundary;
  logic                accumulating;
  ema_totals_type      sums;
  ema_cfg_type         candCfg;
  logic [SCALE_W-1:0]  candScale;
  logic signed [POWER_W:0] pAct, pRea;

  function automatic logic [TOTAL_W-1:0] satAdd(input logic [TOTAL_W-1:0] a,
                                                input logic [TOTAL_W-1:0] b);
    logic [TOTAL_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[TOTAL_W] ? '1 : s[TOTAL_W-1:0];
  endfunction
  // boundary when the minute is a whole multiple of the interval
  function automatic logic aligned(input ema_interval_type iv, input logic [5:0] m);
    case (iv)
      INT_5MIN:  return (m % MIN_5) == 6'h00;
      INT_10MIN: return (m % MIN_10) == 6'h00;
      INT_15MIN: return (m % MIN_15) == 6'h00;
      INT_30MIN: return (m % MIN_30) == 6'h00;
      INT_60MIN: return (m % MIN_60) == 6'h00;
      default:   return 1'b0;
    endcase
  endfunction
  // write value clamped into the weight range
  function automatic logic [SCALE_W-1:0] clampScale(input logic [DATA_W-1:0] w);
    if (w < DATA_W'(SCALE_MIN)) return SCALE_MIN;
    if (w > DATA_W'(SCALE_MAX)) return SCALE_MAX;
    return w[SCALE_W-1:0];
  endfunction
  // meter pulses and clear come from pins
  assign pinVec = {reactiveSupplyPulseIn, reactiveDemandPulseIn, activeSupplyPulseIn,
                   activeDemandPulseIn, totalClearIn};

  for (genvar i = 0; i < PIN_N; i++) begin : g_sync
    ema_pulse_sync u_sync (
      .clk (clk), .sys_rst (sys_rst), .clkEn (clkEn), .pinIn (pinVec[i]),
      .rise (pinRise[i])
    );
  end

  // settings written by software; a rewrite of the same value is no change
  always_comb begin
    next_cfg      = cfg;
    next_actScale = actScale;
    next_reaScale = reaScale;
    settingChange = 1'b0;
    candCfg       = cfg;
    candScale     = clampScale(regWrData);
    if (regWr) begin
      case (regAddr)
        CFG_OFS: begin
          // unknown interval codes keep the old interval
          if (regWrData[CFG_INT_MSB:CFG_INT_LSB] <= INT_CODE_MAX) begin
            candCfg.interval = ema_interval_type'(regWrData[CFG_INT_MSB:CFG_INT_LSB]);
          end
          candCfg.impulse    = regWrData[CFG_IMP_BIT];
          candCfg.cumulative = regWrData[CFG_CUM_BIT];
          candCfg.refSupply  = regWrData[CFG_REF_BIT];
          candCfg.unitMega   = regWrData[CFG_MEGA_BIT];
          settingChange      = candCfg != cfg;
          next_cfg           = candCfg;
        end
        ACT_SCALE_OFS: begin
          settingChange = candScale != actScale;
          next_actScale = candScale;
        end
        REA_SCALE_OFS: begin
          settingChange = candScale != reaScale;
          next_reaScale = candScale;
        end
        default: settingChange = 1'b0;
      endcase
    end
  end
  // event sources for the accumulator
  always_comb begin
    boundary     = rtcMinuteTick && aligned(cfg.interval, rtcMinute);
    clearHit     = pinRise[PIN_CLR] && cfg.cumulative;
    accumulating = !waiting || cfg.interval == INT_OFF;
    pAct         = cfg.refSupply ? -(POWER_W+1)'(activePower) : (POWER_W+1)'(activePower);
    pRea         = cfg.refSupply ? -(POWER_W+1)'(reactivePower) : (POWER_W+1)'(reactivePower);
  end
  // running sums for this cycle
  always_comb begin
    sums = totals;
    if (accumulating) begin
      if (cfg.impulse) begin
        // pins matter only in impulse mode
        if (pinRise[PIN_AD]) begin
          sums.activeDemandTotal = satAdd(sums.activeDemandTotal, TOTAL_W'(actScale));
        end
        if (pinRise[PIN_AS]) begin
          sums.activeSupplyTotal = satAdd(sums.activeSupplyTotal, TOTAL_W'(actScale));
        end
        if (pinRise[PIN_RD]) begin
          sums.reactiveDemandTotal = satAdd(sums.reactiveDemandTotal, TOTAL_W'(reaScale));
        end
        if (pinRise[PIN_RS]) begin
          sums.reactiveSupplyTotal = satAdd(sums.reactiveSupplyTotal, TOTAL_W'(reaScale));
        end
      end else if (powerValid) begin
        // sign picks demand or supply, the four sums stay apart
        if (pAct > 0) begin
          sums.activeDemandTotal = satAdd(sums.activeDemandTotal, TOTAL_W'(pAct));
        end else if (pAct < 0) begin
          sums.activeSupplyTotal = satAdd(sums.activeSupplyTotal, TOTAL_W'(-pAct));
        end
        if (pRea > 0) begin
          sums.reactiveDemandTotal = satAdd(sums.reactiveDemandTotal, TOTAL_W'(pRea));
        end else if (pRea < 0) begin
          sums.reactiveSupplyTotal = satAdd(sums.reactiveSupplyTotal, TOTAL_W'(-pRea));
        end
      end
    end
  end
  // totals and reports; change beats clear beats boundary, an add in the boundary cycle goes into the report
  always_comb begin
    next_totals       = sums;
    next_waiting      = waiting;
    next_report       = 1'b0;
    next_reportTotals = reportTotals;
    if (settingChange) begin
      next_totals  = TOTALS_RST;
      next_waiting = 1'b1;
    end else if (clearHit) begin
      next_totals = TOTALS_RST;
    end else if (boundary) begin
      if (waiting) begin
        // first aligned boundary only starts the fresh interval
        next_waiting = 1'b0;
        next_totals  = TOTALS_RST;
      end else begin
        next_report       = 1'b1;
        next_reportTotals = sums;
        next_totals       = cfg.cumulative ? sums : TOTALS_RST;
      end
    end
  end
  // read data stand for one cycle only, unmapped reads give zero
  always_comb begin
    next_regRdData = '0;
    if (regRd) begin
      case (regAddr)
        CFG_OFS: begin
          next_regRdData[CFG_INT_MSB:CFG_INT_LSB] = cfg.interval;
          next_regRdData[CFG_IMP_BIT]  = cfg.impulse;
          next_regRdData[CFG_CUM_BIT]  = cfg.cumulative;
          next_regRdData[CFG_REF_BIT]  = cfg.refSupply;
          next_regRdData[CFG_MEGA_BIT] = cfg.unitMega;
        end
        ACT_SCALE_OFS: next_regRdData = DATA_W'(actScale);
        REA_SCALE_OFS: next_regRdData = DATA_W'(reaScale);
        STATUS_OFS:    next_regRdData[STAT_ACC_BIT:STAT_WAIT_BIT] = {accumulating, waiting};
        TOT_AD_OFS: next_regRdData = totals.activeDemandTotal;
        TOT_AS_OFS: next_regRdData = totals.activeSupplyTotal;
        TOT_RD_OFS: next_regRdData = totals.reactiveDemandTotal;
        TOT_RS_OFS: next_regRdData = totals.reactiveSupplyTotal;
        default:    next_regRdData = '0;
      endcase
    end
  end
  // restart counts as a change: zero totals, wait for a boundary
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg               <= CFG_RST;
      actScale          <= SCALE_RST;
      reaScale          <= SCALE_RST;
      waiting           <= 1'b1;
      totals            <= TOTALS_RST;
      reportTotals      <= TOTALS_RST;
      eventListStrobe   <= 1'b0;
      supervisoryStrobe <= 1'b0;
      unitIsMega        <= 1'b0;
      regRdData         <= '0;
    end else if (clkEn) begin
      cfg               <= next_cfg;
      actScale          <= next_actScale;
      reaScale          <= next_reaScale;
      waiting           <= next_waiting;
      totals            <= next_totals;
      reportTotals      <= next_reportTotals;
      eventListStrobe   <= next_report;
      supervisoryStrobe <= next_report;
      unitIsMega        <= next_cfg.unitMega;
      regRdData         <= next_regRdData;
    end
  end

  // checks on the accumulator
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_reset_defaults;
    @(posedge clk) disable iff (1'b0)
    sys_rst |=> cfg == CFG_RST && actScale == SCALE_RST && reaScale == SCALE_RST
                && totals == TOTALS_RST;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("settings or totals wrong after reset");
  property p_clear_honoured;
    clkEn && pinRise[PIN_CLR] && cfg.cumulative |=> totals == TOTALS_RST;
  endproperty
  a_clear_honoured: assert property (p_clear_honoured)
    else $error("clear in cumulation mode did not zero totals");
  sequence s_change;
    clkEn && settingChange;
  endsequence
  sequence s_held_zero;
    totals == TOTALS_RST && waiting;
  endsequence
  property p_change_zeroes;
    s_change |=> s_held_zero;
  endproperty
  a_change_zeroes: assert property (p_change_zeroes)
    else $error("setting change left totals standing");
  property p_first_boundary_silent;
    clkEn && waiting && boundary && !settingChange && !clearHit
      |=> !waiting && !eventListStrobe;
  endproperty
  a_first_boundary_silent: assert property (p_first_boundary_silent)
    else $error("report sent at first boundary after change");
  property p_reset_after_report;
    clkEn && !waiting && boundary && !cfg.cumulative && !settingChange
      |=> eventListStrobe && totals == TOTALS_RST;
  endproperty
  a_reset_after_report: assert property (p_reset_after_report)
    else $error("non-cumulative totals kept after report");
  property p_off_silent;
    cfg.interval == INT_OFF && !settingChange |=> !eventListStrobe;
  endproperty
  a_off_silent: assert property (p_off_silent)
    else $error("report with interval off");
  property p_both_reports;
    eventListStrobe |-> supervisoryStrobe && $past(boundary) && $past(clkEn);
  endproperty
  a_both_reports: assert property (p_both_reports)
    else $error("report strobes disagree or came off a boundary");
  property p_aligned;
    clkEn && rtcMinuteTick && !aligned(cfg.interval, rtcMinute) && !settingChange
      |=> !eventListStrobe;
  endproperty
  a_aligned: assert property (p_aligned)
    else $error("report on a minute off the grid");
  property p_pins_ignored;
    clkEn && !cfg.impulse && !powerValid && !boundary && !clearHit && !settingChange
      |=> $stable(totals);
  endproperty
  a_pins_ignored: assert property (p_pins_ignored)
    else $error("totals moved in measurement mode without power");
  sequence s_ad_pulse;
    clkEn && cfg.impulse && accumulating && pinRise[PIN_AD] && !settingChange
      && !clearHit && !boundary;
  endsequence
  property p_pulse_weight;
    s_ad_pulse |=> totals.activeDemandTotal
      == satAdd($past(totals.activeDemandTotal), TOTAL_W'($past(actScale)));
  endproperty
  a_pulse_weight: assert property (p_pulse_weight)
    else $error("pulse did not add its weight");
  property p_power_demand;
    clkEn && !cfg.impulse && accumulating && powerValid && pAct > 0 && !settingChange
      && !clearHit && !boundary
      |=> totals.activeDemandTotal
      == satAdd($past(totals.activeDemandTotal), TOTAL_W'($past(pAct)))
      && $stable(totals.activeSupplyTotal);
  endproperty
  a_power_demand: assert property (p_power_demand)
    else $error("positive power not added to demand");

endmodule

/* ema_accumulator_tb.sv */
`timescale 1ns/10ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

module ema_accumulator_tb;
  import ema_pkg::*;
  // clock, reset and register port
  logic                      clk, sys_rst, clkEn, regWr, regRd;
  logic [ADDR_W-1:0]         regAddr;
  logic [DATA_W-1:0]         regWrData, regRdData, rdData;
  // measurement and real-time clock
  logic                      powerValid, rtcMinuteTick;
  logic signed [POWER_W-1:0] activePower, reactivePower;
  logic [5:0]                rtcMinute;
  // pins and outputs
  logic [PIN_N-1:0]          pinFire, pins;
  ema_totals_type            totals, reportTotals;
  logic                      eventListStrobe, supervisoryStrobe, unitIsMega;
  int                        err_total, cmp_count;

  ema_accumulator dut (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .powerValid(powerValid), .activePower(activePower), .reactivePower(reactivePower),
    .rtcMinuteTick(rtcMinuteTick), .rtcMinute(rtcMinute), .totalClearIn(pins[PIN_CLR]),
    .activeDemandPulseIn(pins[PIN_AD]), .activeSupplyPulseIn(pins[PIN_AS]),
    .reactiveDemandPulseIn(pins[PIN_RD]), .reactiveSupplyPulseIn(pins[PIN_RS]),
    .totals(totals), .reportTotals(reportTotals), .eventListStrobe(eventListStrobe),
    .supervisoryStrobe(supervisoryStrobe), .unitIsMega(unitIsMega));

  ema_meter_model meter (.clk(clk), .sys_rst(sys_rst), .fire(pinFire), .pins(pins));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // bus cycles: strobe for one cycle, results looked at just after the taking edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk) begin regWr <= 1'b1; regAddr <= a; regWrData <= d; end
    @(posedge clk) regWr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk) begin regRd <= 1'b1; regAddr <= a; end
    @(posedge clk) regRd <= 1'b0;
    #1 rdData = regRdData;
  endtask

  task automatic tick(input logic [5:0] m);
    @(posedge clk) begin rtcMinuteTick <= 1'b1; rtcMinute <= m; end
    @(posedge clk) rtcMinuteTick <= 1'b0;
    #1;
  endtask

  task automatic pwr(input logic signed [POWER_W-1:0] a, r);
    @(posedge clk) begin powerValid <= 1'b1; activePower <= a; reactivePower <= r; end
    @(posedge clk) powerValid <= 1'b0;
    #1;
  endtask

  // generous settle: three sync stages plus the add
  task automatic pulse(input logic [PIN_N-1:0] m);
    @(posedge clk) pinFire <= m;
    @(posedge clk) pinFire <= '0;
    repeat (12) @(posedge clk);
    #1;
  endtask

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic scen_reset_values;
    rd(CFG_OFS);
    `CHK(rdData, 32'h00000004)
    `CHK(unitIsMega, 1'b0)
    rd(ACT_SCALE_OFS);
    `CHK(rdData, 32'h00000064)
    rd(REA_SCALE_OFS);
    `CHK(rdData, 32'h00000064)
    rd(8'h20);
    `CHK(rdData, 32'h00000000)
    rd(STATUS_OFS);
    `CHK(rdData[STAT_WAIT_BIT], 1'b1)
  endtask

  task automatic scen_measure;
    pwr(24'h00000a, 24'hfffff9);
    `CHK(totals, TOTALS_RST)
    tick(6'h00);
    `CHK({eventListStrobe, supervisoryStrobe}, 2'b00)
    pwr(24'h00000a, 24'hfffff9);
    `CHK(totals, ema_totals_type'{32'ha, 32'h0, 32'h0, 32'h7})
    tick(6'h0f);
    `CHK(eventListStrobe, 1'b0)
    tick(6'h1e);
    `CHK({eventListStrobe, supervisoryStrobe}, 2'b11)
    `CHK(reportTotals, ema_totals_type'{32'ha, 32'h0, 32'h0, 32'h7})
    `CHK(totals, TOTALS_RST)
  endtask

  task automatic scen_reference;
    wr(CFG_OFS, 32'h00000024);
    tick(6'h00);
    pwr(24'h00000a, 24'hfffff9);
    `CHK(totals, ema_totals_type'{32'h0, 32'ha, 32'h7, 32'h0})
    wr(CFG_OFS, 32'h00000064);
    `CHK(totals, TOTALS_RST)
    `CHK(unitIsMega, 1'b1)
    rd(STATUS_OFS);
    `CHK(rdData[STAT_WAIT_BIT], 1'b1)
  endtask

  task automatic scen_impulse;
    wr(ACT_SCALE_OFS, 32'h00000000);
    rd(ACT_SCALE_OFS);
    `CHK(rdData, 32'h00000001)
    wr(ACT_SCALE_OFS, 32'h00004e20);
    rd(ACT_SCALE_OFS);
    `CHK(rdData, 32'h00002710)
    wr(ACT_SCALE_OFS, 32'h00000003);
    wr(CFG_OFS, 32'h0000000b);
    tick(6'h07);
    pulse(5'h02);
    `CHK(totals, TOTALS_RST)
    tick(6'h2d);
    pulse(5'h1e);
    `CHK(totals, ema_totals_type'{32'h3, 32'h3, 32'h64, 32'h64})
    pulse(5'h01);
    `CHK(totals, ema_totals_type'{32'h3, 32'h3, 32'h64, 32'h64})
    pwr(24'h00000a, 24'hfffff9);
    `CHK(totals, ema_totals_type'{32'h3, 32'h3, 32'h64, 32'h64})
    tick(6'h00);
    `CHK(reportTotals, ema_totals_type'{32'h3, 32'h3, 32'h64, 32'h64})
    `CHK(totals, TOTALS_RST)
  endtask

  task automatic scen_cumulate;
    wr(CFG_OFS, 32'h0000001b);
    tick(6'h00);
    pulse(5'h02);
    tick(6'h0f);
    `CHK(eventListStrobe, 1'b1)
    `CHK(totals.activeDemandTotal, 32'h00000003)
    pulse(5'h02);
    `CHK(totals.activeDemandTotal, 32'h00000006)
    pulse(5'h01);
    `CHK(totals, TOTALS_RST)
  endtask

  task automatic scen_off_and_codes;
    logic [2:0] c;
    wr(CFG_OFS, 32'h00000008);
    pulse(5'h02);
    `CHK(totals.activeDemandTotal, 32'h00000003)
    tick(6'h00);
    `CHK(eventListStrobe, 1'b0)
    for (c = 3'h1; c <= INT_CODE_MAX; c++) begin
      wr(CFG_OFS, {29'h0, c});
      rd(CFG_OFS);
      `CHK(rdData[2:0], c)
    end
    wr(CFG_OFS, 32'h00000006);
    rd(CFG_OFS);
    `CHK(rdData[2:0], 3'h5)
  endtask

  // enable low must freeze the adder; a restart mid-run zeroes and waits again
  task automatic scen_freeze;
    tick(6'h00);
    @(posedge clk) clkEn <= 1'b0;
    pwr(24'h000005, 24'h000000);
    `CHK(totals, TOTALS_RST)
    @(posedge clk) clkEn <= 1'b1;
    pwr(24'h000005, 24'h000000);
    `CHK(totals.activeDemandTotal, 32'h00000005)
    pulse(5'h1e);
    `CHK(totals.activeDemandTotal, 32'h00000005)
    @(posedge clk) sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    `CHK(totals, TOTALS_RST)
    rd(STATUS_OFS);
    `CHK(rdData[STAT_WAIT_BIT], 1'b1)
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report;
  end

  initial begin
    err_total = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    clkEn = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = '0;
    regWrData = '0;
    powerValid = 1'b0;
    activePower = '0;
    reactivePower = '0;
    rtcMinuteTick = 1'b0;
    rtcMinute = 6'h00;
    pinFire = '0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    scen_reset_values();
    scen_measure();
    scen_reference();
    scen_impulse();
    scen_cumulate();
    scen_off_and_codes();
    scen_freeze();
    final_report;
  end
endmodule

/* ema_meter_model.sv */
`timescale 1ns/10ps

// external meter: one request fires a pulse on each selected pin
module ema_meter_model
  import ema_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // request from the bench
  input  wire logic [PIN_N-1:0] fire,
  // meter and clear pins
  output logic      [PIN_N-1:0] pins
);
  logic [PIN_N-1:0] mask;
  logic [2:0]       cnt;

  // three cycles high, at least four low; the sync stages need at least two of each
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask <= '0;
      cnt  <= 3'h0;
    end else if (cnt == 3'h0) begin
      if (fire != '0) begin
        mask <= fire;
        cnt  <= 3'h6;
      end
    end else begin
      cnt <= cnt - 3'h1;
    end
  end

  // line returns low between pulses, so each rise is a new pulse
  assign pins = (cnt > 3'h3) ? mask : '0;
endmodule

/* ema_pkg.sv */
package ema_pkg;

  // widths of the datapath
  localparam int DATA_W  = 32;
  localparam int ADDR_W  = 8;
  localparam int TOTAL_W = 32;
  localparam int POWER_W = 24;
  localparam int SCALE_W = 14;
  localparam int PIN_N   = 5;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CFG_OFS       = 8'h00;
  localparam logic [ADDR_W-1:0] ACT_SCALE_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] REA_SCALE_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFS    = 8'h0c;
  localparam logic [ADDR_W-1:0] TOT_AD_OFS    = 8'h10;
  localparam logic [ADDR_W-1:0] TOT_AS_OFS    = 8'h14;
  localparam logic [ADDR_W-1:0] TOT_RD_OFS    = 8'h18;
  localparam logic [ADDR_W-1:0] TOT_RS_OFS    = 8'h1c;

  // config register field positions
  localparam int CFG_INT_LSB  = 0;
  localparam int CFG_INT_MSB  = 2;
  localparam int CFG_IMP_BIT  = 3;
  localparam int CFG_CUM_BIT  = 4;
  localparam int CFG_REF_BIT  = 5;
  localparam int CFG_MEGA_BIT = 6;

  // status register field positions
  localparam int STAT_WAIT_BIT = 0;
  localparam int STAT_ACC_BIT  = 1;

  // pin vector positions
  localparam int PIN_CLR = 0;
  localparam int PIN_AD  = 1;
  localparam int PIN_AS  = 2;
  localparam int PIN_RD  = 3;
  localparam int PIN_RS  = 4;

  // pulse weight range and value after reset
  localparam logic [SCALE_W-1:0] SCALE_MIN = 14'h0001;
  localparam logic [SCALE_W-1:0] SCALE_MAX = 14'h2710;
  localparam logic [SCALE_W-1:0] SCALE_RST = 14'h0064;

  // interval lengths in minutes
  localparam logic [5:0] MIN_5  = 6'h05;
  localparam logic [5:0] MIN_10 = 6'h0a;
  localparam logic [5:0] MIN_15 = 6'h0f;
  localparam logic [5:0] MIN_30 = 6'h1e;
  localparam logic [5:0] MIN_60 = 6'h3c;
  localparam logic [2:0] INT_CODE_MAX = 3'h5;

  typedef enum logic [2:0] {
    INT_OFF, INT_5MIN, INT_10MIN, INT_15MIN, INT_30MIN, INT_60MIN
  } ema_interval_type;

  typedef struct packed {
    ema_interval_type interval;
    logic             impulse;
    logic             cumulative;
    logic             refSupply;
    logic             unitMega;
  } ema_cfg_type;

  typedef struct packed {
    logic [TOTAL_W-1:0] activeDemandTotal;
    logic [TOTAL_W-1:0] activeSupplyTotal;
    logic [TOTAL_W-1:0] reactiveDemandTotal;
    logic [TOTAL_W-1:0] reactiveSupplyTotal;
  } ema_totals_type;

  // values after reset
  localparam ema_cfg_type    CFG_RST    = '{INT_30MIN, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam ema_totals_type TOTALS_RST = '0;

endpackage

/* ema_pulse_sync.sv */
`timescale 1ns/10ps

// three-stage pin synchroniser with a rising-edge pulse
module ema_pulse_sync (
  // clock and reset
  input  logic clk,
  input  logic sys_rst,
  input  logic clkEn,
  // pin and edge
  input  logic pinIn,
  output logic rise
);
  import ema_pkg::*;

  logic [2:0] stage;
  logic       stable;
  logic [2:0] next_stage;
  logic       next_stable;
  logic       next_rise;

  // only a level the last two stages agree on counts
  always_comb begin
    next_stage  = {stage[1:0], pinIn};
    next_stable = stable;
    next_rise   = 1'b0;
    if (stage[1] == stage[2]) begin
      next_stable = stage[2];
      next_rise   = stage[2] && !stable;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage  <= 3'h0;
      stable <= 1'b0;
      rise   <= 1'b0;
    end else if (clkEn) begin
      stage  <= next_stage;
      stable <= next_stable;
      rise   <= next_rise;
    end
  end

endmodule
